// *** hw/hbr_consts.svh ***
// constants for the host bus narrow read path
`ifndef HBR_CONSTS_SVH
`define HBR_CONSTS_SVH

// byte address bounds of the spaces seen by the host
`define HBR_REG_END      24'h00FBFF
`define HBR_SDRAM_BASE   24'h010000

// strap settle count after reset release (two sync stages)
`define HBR_STRAP_SETTLE 2'h2

// reset values
`define HBR_RDATA_RST    32'h0000_0000
`define HBR_LATCH_RST    32'h0000_0000

`endif

// *** hw/hbr_lane_if.sv ***
// read lane selection signals between the bus path and the lane mux
`timescale 1ns/1ps
`default_nettype none
interface hbr_lane_if;
  import hbr_pkg::*;
  logic [31:0] word;    // source register word
  logic [1:0]  ofs;     // byte offset of the access
  hbr_size_t   size;    // access size
  logic        mode16;  // 16-bit data mode
  logic [31:0] data;    // data as placed on the host bus

  modport src (output word, output ofs, output size, output mode16, input data);
  modport mux (input word, input ofs, input size, input mode16, output data);
endinterface : hbr_lane_if
`default_nettype wire

// *** hw/hbr_lane_mux.sv ***
// places the selected bytes of a register word onto the host data lanes
`timescale 1ns/1ps
`default_nettype none
module hbr_lane_mux (
  hbr_lane_if.mux lane  // lane selection
);
  import hbr_pkg::*;

  logic [3:0]  strb;
  logic [31:0] masked;

  always_comb begin
    strb   = hbr_strb(lane.size, lane.ofs);
    masked = lane.word & {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    // on the narrow bus the addressed half travels on the low 16 lanes
    if (lane.mode16) begin
      lane.data = {16'h0000, (lane.ofs[1] ? masked[15:0] : masked[31:16])};
    end else begin
      lane.data = masked;
    end
  end

endmodule : hbr_lane_mux
`default_nettype wire

// *** hw/hbr_pkg.sv ***
// types and lane helpers for the host bus narrow read path
package hbr_pkg;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } hbr_size_t;

  typedef enum logic [1:0] {
    RG_REG   = 2'h0,
    RG_SDRAM = 2'h1,
    RG_OTHER = 2'h2
  } hbr_region_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_WRITE = 2'h2
  } hbr_state_t;

  // big-endian byte lanes: offset 0 is bits 31:24
  function automatic logic [3:0] hbr_strb(input hbr_size_t sz, input logic [1:0] ofs);
    case (sz)
      SZ_BYTE: hbr_strb = 4'h8 >> ofs;
      SZ_HALF: hbr_strb = ofs[1] ? 4'h3 : 4'hC;
      default: hbr_strb = 4'hF;
    endcase
  endfunction : hbr_strb

endpackage : hbr_pkg

// *** hw/hbr_top.sv ***
// host bus read/write path with 16/32-bit strap and narrow read latch
`timescale 1ns/1ps
`default_nettype none
`include "hbr_consts.svh"

// Overview of operation
// - strap low selects 16-bit, high 32-bit
// - writes work in every mode and size except word size in 16-bit mode, which stores the low halfword in both halves
// - 16-bit word reads arrive MSB half first
// - narrow handling covers registers and SDRAM
// - offsets 0/1 always fetch the word fresh
module hbr_top #(
  parameter int AW = 24  // host byte address width
) (
  input  wire logic              i_sys_clk,    // bus clock
  input  wire logic              i_rst_n,      // async reset, active low
  input  wire logic              i_mode_strap, // width strap pin
  input  wire logic              i_req,        // host access strobe
  input  wire logic              i_we,         // 1 write, 0 read
  input  wire hbr_pkg::hbr_size_t i_size,      // access size
  input  wire logic [AW-1:0]     i_addr,       // byte address
  input  wire logic [31:0]       i_wdata,      // write data
  output logic                   o_rdy,        // access done pulse
  output logic [31:0]            o_rdata,      // read data
  output logic                   o_mode_32,    // captured width, 1 = 32-bit
  output logic                   o_cfg_done,   // strap captured
  output logic                   o_be_req,     // backend access pulse
  output logic                   o_be_we,      // backend write
  output logic                   o_be_sdram,   // backend target is SDRAM
  output logic [AW-3:0]          o_be_addr,    // backend word index
  output logic [3:0]             o_be_strb,    // backend byte strobes
  output logic [31:0]            o_be_wdata,   // backend write data
  input  wire logic              i_be_ack,     // backend done pulse
  input  wire logic [31:0]       i_be_rdata    // backend read word
);
  import hbr_pkg::*;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  function automatic hbr_region_t region_of(input logic [AW-1:0] a);
    if (a <= AW'(`HBR_REG_END)) begin
      region_of = RG_REG;
    end else if (a >= AW'(`HBR_SDRAM_BASE)) begin
      region_of = RG_SDRAM;
    end else begin
      region_of = RG_OTHER;
    end
  endfunction : region_of

  logic        strap_s1_reg;
  logic        strap_s2_reg;
  logic [1:0]  settle_reg;
  hbr_state_t  state_reg;
  logic        req_we_reg;
  hbr_size_t   req_size_reg;
  logic [1:0]  req_ofs_reg;
  hbr_region_t req_region_reg;
  logic [31:0] latch_word_reg;
  logic [AW-3:0] latch_idx_reg;
  logic        latch_vld_reg;
  logic        mode16;
  logic        take;
  logic        hit;
  logic        rd_done;
  logic [3:0]  take_strb;
  hbr_region_t take_region;

  hbr_lane_if lane ();

  hbr_lane_mux u_lane_mux (
    .lane (lane.mux)
  );

  // strap sampled through two stages, then frozen once settled
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_s1_reg <= 1'b0;
      strap_s2_reg <= 1'b0;
      settle_reg   <= 2'h0;
      o_mode_32    <= 1'b0;
      o_cfg_done   <= 1'b0;
    end else begin
      strap_s1_reg <= i_mode_strap;
      strap_s2_reg <= strap_s1_reg;
      if (!o_cfg_done) begin
        if (settle_reg == `HBR_STRAP_SETTLE) begin
          o_mode_32  <= strap_s2_reg;
          o_cfg_done <= 1'b1;
        end else begin
          settle_reg <= settle_reg + 2'h1;
        end
      end
    end
  end

  assign mode16      = !o_mode_32;
  assign take        = i_req && (state_reg == ST_IDLE) && o_cfg_done;
  assign take_strb   = hbr_strb(i_size, i_addr[1:0]);
  assign take_region = region_of(i_addr);
  assign rd_done     = (state_reg == ST_FETCH) && i_be_ack;
  // a second-half read is served only right after its first-half read
  assign hit = mode16 && !i_we && i_addr[1] && latch_vld_reg &&
               (latch_idx_reg == i_addr[AW-1:2]) && (take_region != RG_OTHER);

  always_comb begin
    if (state_reg == ST_FETCH) begin
      lane.word = i_be_rdata;
      lane.ofs  = req_ofs_reg;
      lane.size = req_size_reg;
    end else begin
      lane.word = latch_word_reg;
      lane.ofs  = i_addr[1:0];
      lane.size = i_size;
    end
    lane.mode16 = mode16;
  end

  // request sequencing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg      <= ST_IDLE;
      req_we_reg     <= 1'b0;
      req_size_reg   <= SZ_WORD;
      req_ofs_reg    <= 2'h0;
      req_region_reg <= RG_REG;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && !hit) begin
            req_we_reg     <= i_we;
            req_size_reg   <= i_size;
            req_ofs_reg    <= i_addr[1:0];
            req_region_reg <= take_region;
            state_reg      <= i_we ? ST_WRITE : ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (i_be_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (i_be_ack) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // backend access; narrow writes carry the halfword on both halves
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_be_req   <= 1'b0;
      o_be_we    <= 1'b0;
      o_be_sdram <= 1'b0;
      o_be_addr  <= '0;
      o_be_strb  <= 4'h0;
      o_be_wdata <= 32'h0000_0000;
    end else begin
      o_be_req <= take && !hit;
      if (take && !hit) begin
        o_be_we    <= i_we;
        o_be_sdram <= (take_region == RG_SDRAM);
        o_be_addr  <= i_addr[AW-1:2];
        o_be_strb  <= i_we ? take_strb : 4'hF;
        o_be_wdata <= mode16 ? {i_wdata[15:0], i_wdata[15:0]} : i_wdata;
      end
    end
  end

  // answer to the host
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdy   <= 1'b0;
      o_rdata <= `HBR_RDATA_RST;
    end else begin
      o_rdy <= (take && hit) || ((state_reg != ST_IDLE) && i_be_ack);
      if ((take && hit) || rd_done) begin
        o_rdata <= lane.data;
      end
    end
  end

  // first-half latch; any other access breaks the pairing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_word_reg <= `HBR_LATCH_RST;
      latch_idx_reg  <= '0;
      latch_vld_reg  <= 1'b0;
    end else begin
      if (rd_done && mode16 && !req_ofs_reg[1] && (req_region_reg != RG_OTHER)) begin
        latch_word_reg <= i_be_rdata;
        latch_idx_reg  <= o_be_addr;
        latch_vld_reg  <= 1'b1;
      end else if (take || (state_reg == ST_WRITE)) begin
        latch_vld_reg  <= 1'b0;
      end
    end
  end

  sequence s_take_rd;
    take && !i_we;
  endsequence

  sequence s_rd_done;
    rd_done && !req_we_reg;
  endsequence

  a_hit_serve: assert property (take && hit |=> o_rdy && !o_be_req)
    else $error("latched read did not answer in one cycle");
  a_hit_data: assert property (take && hit && i_size == SZ_HALF
      |=> o_rdata[15:0] == $past(latch_word_reg[15:0]))
    else $error("second half not served from latch");
  a_low_fetch: assert property (s_take_rd ##0 (mode16 && !i_addr[1])
      |=> o_be_req && !o_be_we)
    else $error("first half read did not fetch the word");
  a_latch_fill: assert property (s_rd_done ##0 (mode16 && !req_ofs_reg[1] &&
      req_region_reg != RG_OTHER) |=> latch_vld_reg && latch_word_reg == $past(i_be_rdata))
    else $error("latch not filled by first half read");
  a_other_bypass: assert property (s_rd_done ##0 (req_region_reg == RG_OTHER)
      |=> !latch_vld_reg)
    else $error("latch filled outside register and memory space");
  a_word32_data: assert property (s_rd_done ##0 (!mode16 && req_size_reg == SZ_WORD)
      |=> o_rdy && o_rdata == $past(i_be_rdata))
    else $error("word read in 32-bit mode returned wrong data");
  a_msb_first: assert property (s_rd_done ##0 (mode16 && req_ofs_reg == 2'h0 &&
      req_size_reg == SZ_HALF) |=> o_rdata[15:0] == $past(i_be_rdata[31:16]))
    else $error("first half of a narrow word read is not the upper half");
  a_half16_zero: assert property (o_rdy && mode16 |-> o_rdata[31:16] == 16'h0000)
    else $error("narrow mode drives upper data lanes");
  a_write_path: assert property (take && i_we
      |=> o_be_req && o_be_we && o_be_strb == $past(take_strb) ##1 !o_be_req)
    else $error("write not passed to backend with its strobes");

endmodule : hbr_top
`default_nettype wire

// *** testbench/hbr_be_model.sv ***
// backend store answering the bus path, promptly or with wait cycles
`timescale 1ns/1ps
`default_nettype none
module hbr_be_model (
  input  wire logic        i_clk,   // bus clock
  input  wire logic        i_slow,  // add wait cycles before ack
  input  wire logic        i_req,   // access pulse
  input  wire logic        i_we,    // write
  input  wire logic        i_sd,    // sdram space
  input  wire logic [4:0]  i_idx,   // low word index
  input  wire logic [3:0]  i_strb,  // byte strobes
  input  wire logic [31:0] i_wd,    // write data
  output logic             o_ack,   // done pulse
  output logic [31:0]      o_rd     // read word
);
  logic [31:0] mem [64];
  logic [5:0]  a;
  logic [2:0]  cnt;
  logic        pend;
  logic        w;
  logic [3:0]  s;
  logic [31:0] d;

  initial begin
    o_ack = 1'b0;
    pend  = 1'b0;
    o_rd  = 32'h0;
  end

  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // data is not held outside the ack cycle, so a late capture shows
    o_rd  <= ~o_rd;
    if (i_req) begin
      pend <= 1'b1;
      cnt  <= i_slow ? 3'h3 : 3'h0;
      a    <= {i_sd, i_idx};
      w    <= i_we;
      s    <= i_strb;
      d    <= i_wd;
    end else if (pend) begin
      if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else begin
        pend  <= 1'b0;
        o_ack <= 1'b1;
        if (w) begin
          for (int i = 0; i < 4; i++) if (s[i]) mem[a][i*8+:8] <= d[i*8+:8];
        end else begin
          o_rd <= mem[a];
        end
      end
    end
  end
endmodule : hbr_be_model
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the host bus narrow read path
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
  import hbr_pkg::*;
  logic        clk, rst_n, strap, req, we, rdy, m32, cfg, slow;
  logic        be_req, be_we, be_sd, ack;
  hbr_size_t   sz;
  logic [23:0] addr;
  logic [31:0] wd, rd, be_wd, be_rd, got;
  logic [21:0] be_a;
  logic [3:0]  be_s;
  int          n_mismatch, cmp_count, n_be, lat;

  hbr_top u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_mode_strap(strap), .i_req(req),
    .i_we(we), .i_size(sz), .i_addr(addr), .i_wdata(wd), .o_rdy(rdy), .o_rdata(rd),
    .o_mode_32(m32), .o_cfg_done(cfg), .o_be_req(be_req), .o_be_we(be_we),
    .o_be_sdram(be_sd), .o_be_addr(be_a), .o_be_strb(be_s), .o_be_wdata(be_wd),
    .i_be_ack(ack), .i_be_rdata(be_rd));

  hbr_be_model u_be (.i_clk(clk), .i_slow(slow), .i_req(be_req), .i_we(be_we),
    .i_sd(be_sd), .i_idx(be_a[4:0]), .i_strb(be_s), .i_wd(be_wd), .o_ack(ack),
    .o_rd(be_rd));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (be_req === 1'b1) n_be++;

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic start(input logic s);
    int k;
    rst_n = 1'b0;
    strap = s;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    for (k = 0; k < 20 && cfg !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (cfg !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : start

  // request held until the answer is seen, since a latched hit answers on the very
  // next edge; an idle edge between calls keeps the strobe from toggling twice at once
  task automatic acc(input logic w, input hbr_size_t s, input logic [23:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    #1;
    req  = 1'b1;
    we   = w;
    sz   = s;
    addr = a;
    wd   = d;
    lat = 0;
    do begin
      @(posedge clk);
      #1;
      lat++;
    end while (rdy !== 1'b1 && lat < 40);
    req = 1'b0;
    if (rdy !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    got = rd;
  endtask : acc

  function automatic logic [31:0] exp_rd(input logic m, input hbr_size_t s,
                                          input logic [1:0] o, input logic [31:0] w);
    logic [31:0] k;
    k = (s == SZ_WORD) ? 32'hFFFF_FFFF : (s == SZ_HALF) ?
        (o[1] ? 32'h0000_FFFF : 32'hFFFF_0000) : (32'hFF00_0000 >> (8 * o));
    k = k & w;
    exp_rd = m ? k : {16'h0, o[1] ? k[15:0] : k[31:16]};
  endfunction : exp_rd

  // l = 0 leaves latency unchecked
  task automatic rchk(input hbr_size_t s, input logic [23:0] a, input logic [31:0] w,
                      input int l);
    acc(1'b0, s, a, 32'h0);
    `CHK("rdata", exp_rd(strap, s, a[1:0], w), got);
    if (l > 0) `CHK("latency", l, lat);
  endtask : rchk

  task automatic t_wide;
    start(1'b1);
    `CHK("mode", 1'b1, m32);
    acc(1'b1, SZ_WORD, 24'h000100, 32'h1122_3344);
    acc(1'b1, SZ_BYTE, 24'h000101, 32'h00AB_0000);
    acc(1'b1, SZ_HALF, 24'h000102, 32'h0000_CDEF);
    rchk(SZ_WORD, 24'h000100, 32'h11AB_CDEF, 0);
    rchk(SZ_HALF, 24'h000102, 32'h11AB_CDEF, 0);
    rchk(SZ_BYTE, 24'h000103, 32'h11AB_CDEF, 0);
    rchk(SZ_BYTE, 24'h000101, 32'h11AB_CDEF, 0);
    slow = 1'b1;
    acc(1'b1, SZ_WORD, 24'h010040, 32'h8765_4321);
    rchk(SZ_WORD, 24'h010040, 32'h8765_4321, 0);
    slow = 1'b0;
  endtask : t_wide

  task automatic t_narrow;
    int n0;
    start(1'b0);
    `CHK("mode", 1'b0, m32);
    acc(1'b1, SZ_HALF, 24'h000200, 32'h0000_A1B2);
    acc(1'b1, SZ_HALF, 24'h000202, 32'h0000_C3D4);
    n0 = n_be;
    // word taken as two halves, upper half first, second served from the latch
    rchk(SZ_HALF, 24'h000200, 32'hA1B2_C3D4, 0);
    rchk(SZ_HALF, 24'h000202, 32'hA1B2_C3D4, 1);
    `CHK("be count", n0 + 1, n_be);
    acc(1'b1, SZ_HALF, 24'h010300, 32'h0000_5566);
    acc(1'b1, SZ_HALF, 24'h010302, 32'h0000_7788);
    slow = 1'b1;
    rchk(SZ_BYTE, 24'h010301, 32'h5566_7788, 0);
    rchk(SZ_BYTE, 24'h010303, 32'h5566_7788, 1);
    // an intervening read breaks the pair; the later read must still be right
    rchk(SZ_BYTE, 24'h000200, 32'hA1B2_C3D4, 0);
    rchk(SZ_HALF, 24'h010300, 32'h5566_7788, 0);
    n0 = n_be;
    rchk(SZ_BYTE, 24'h000203, 32'hA1B2_C3D4, 0);
    `CHK("be count", n0 + 1, n_be);
    // space between the register range and SDRAM never pairs; the model folds it onto word 0
    n0 = n_be;
    rchk(SZ_HALF, 24'h00FC00, 32'hA1B2_C3D4, 0);
    rchk(SZ_HALF, 24'h00FC02, 32'hA1B2_C3D4, 0);
    `CHK("be count", n0 + 2, n_be);
    slow = 1'b0;
  endtask : t_narrow

  initial begin
    req   = 1'b0;
    we    = 1'b0;
    sz    = SZ_WORD;
    addr  = 24'h0;
    wd    = 32'h0;
    slow  = 1'b0;
    t_wide();
    t_narrow();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
